// ---- design/dac_host_ctrl.sv ----
`timescale 1ns/1ps
// Functional notes
// - one shared load strobe may update many
// - each access moves one 16-bit word
// - select low, write: store selected register
// - load rising with select high updates outputs
// - channel line low first, high second
// - words are unsigned straight binary
module dac_host_ctrl
    import dac_host_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // user side
    input  wire logic              wrReq,
    input  wire logic              rdReq,
    input  wire logic              loadReq,
    input  wire logic              rstReq,
    input  wire logic              chanSel,
    input  wire logic [DATA_W-1:0] wrData,
    output logic                   busy,
    output logic                   rdValid,
    output logic [DATA_W-1:0]      rdData,
    // device pins
    output logic                   chipSel_n,
    output logic                   readNotWrite,
    output logic                   channel_select,
    output logic                   load_outputs_strobe,
    output logic                   devReset,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   dataOe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        seq_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic              isRead;
        logic              pendRst;
        logic              busy;
        logic              rdValid;
        logic [DATA_W-1:0] rdData;
        logic              csN;
        logic              rnw;
        logic              chan;
        logic              load;
        logic              rst;
        logic [DATA_W-1:0] dOut;
        logic              dOe;
    } ctl_t;

    ctl_t ctl_ff;
    ctl_t nxt_ctl;
    logic [DATA_W-1:0] dSync1_ff;
    logic [DATA_W-1:0] dSync2_ff;

    // two-flop sampling of the returned data bus
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dSync1_ff <= '0;
            dSync2_ff <= '0;
        end else begin
            dSync1_ff <= dataIn;
            dSync2_ff <= dSync1_ff;
        end
    end

    function automatic logic [CNT_W-1:0] ld(input int n);
        return CNT_W'(n - 1);
    endfunction : ld

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_ctl.rdValid = 1'b0;
        if (ctl_ff.cnt != '0) begin
            nxt_ctl.cnt = ctl_ff.cnt - 1'b1;
        end
        case (ctl_ff.st)
            ST_IDLE: begin
                nxt_ctl.busy = 1'b0;
                if (ctl_ff.pendRst || rstReq) begin
                    // first pulse after power-up, and on request
                    nxt_ctl.pendRst = 1'b0;
                    nxt_ctl.rst     = 1'b1;
                    nxt_ctl.busy    = 1'b1;
                    nxt_ctl.cnt     = ld(C_RST_HIGH);
                    nxt_ctl.st      = ST_RST_HIGH;
                end else if (loadReq) begin
                    // chip select stays high through the load edge
                    nxt_ctl.load = 1'b1;
                    nxt_ctl.busy = 1'b1;
                    nxt_ctl.cnt  = ld(C_LOAD_HIGH);
                    nxt_ctl.st   = ST_LOAD_HIGH;
                end else if (wrReq || rdReq) begin
                    // lines set up before chip select falls
                    nxt_ctl.isRead = rdReq && !wrReq;
                    nxt_ctl.rnw    = rdReq && !wrReq;
                    nxt_ctl.chan   = chanSel;
                    nxt_ctl.dOut   = wrData;
                    nxt_ctl.dOe    = !(rdReq && !wrReq);
                    nxt_ctl.busy   = 1'b1;
                    nxt_ctl.cnt    = ld(C_SETUP);
                    nxt_ctl.st     = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.csN = 1'b0;
                    nxt_ctl.cnt = ctl_ff.isRead ? ld(C_READ + C_SYNC) : ld(C_WRITE);
                    nxt_ctl.st  = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (ctl_ff.cnt == '0) begin
                    if (ctl_ff.isRead) begin
                        // read-back word, two sync cycles late
                        nxt_ctl.rdData  = dSync2_ff;
                        nxt_ctl.rdValid = 1'b1;
                    end
                    nxt_ctl.csN = 1'b1;
                    nxt_ctl.cnt = ld(C_HOLD);
                    nxt_ctl.st  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.dOe = 1'b0;
                    nxt_ctl.rnw = 1'b1;
                    nxt_ctl.cnt = ld(C_RELEASE);
                    nxt_ctl.st  = ctl_ff.isRead ? ST_RELEASE : ST_IDLE;
                end
            end
            ST_RELEASE: begin
                // wait for the device to float the bus
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.st = ST_IDLE;
                end
            end
            ST_LOAD_HIGH: begin
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.load = 1'b0;
                    nxt_ctl.cnt  = ld(C_LOAD_LOW);
                    nxt_ctl.st   = ST_LOAD_LOW;
                end
            end
            ST_LOAD_LOW: begin
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.st = ST_IDLE;
                end
            end
            ST_RST_HIGH: begin
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.rst = 1'b0;
                    nxt_ctl.cnt = ld(C_RST_LOW);
                    nxt_ctl.st  = ST_RST_LOW;
                end
            end
            ST_RST_LOW: begin
                if (ctl_ff.cnt == '0) begin
                    nxt_ctl.st = ST_IDLE;
                end
            end
            default: begin
                nxt_ctl.st = ST_IDLE;
            end
        endcase
    end

    // register the state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_ff         <= '0;
            ctl_ff.st      <= ST_IDLE;
            ctl_ff.pendRst <= 1'b1;
            ctl_ff.busy    <= 1'b1;
            ctl_ff.csN     <= 1'b1;
            ctl_ff.rnw     <= 1'b1;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign busy                = ctl_ff.busy;
    assign rdValid             = ctl_ff.rdValid;
    assign rdData              = ctl_ff.rdData;
    assign chipSel_n           = ctl_ff.csN;
    assign readNotWrite        = ctl_ff.rnw;
    assign channel_select      = ctl_ff.chan;
    assign load_outputs_strobe = ctl_ff.load;
    assign devReset            = ctl_ff.rst;
    assign dataOut             = ctl_ff.dOut;
    assign dataOe              = ctl_ff.dOe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_load_cs_high: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(load_outputs_strobe) |-> chipSel_n)
        else $error("load edge while selected");
    a_load_width: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(load_outputs_strobe) |-> load_outputs_strobe [*2])
        else $error("load strobe too short");
    a_write_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        (!chipSel_n && !readNotWrite) |-> dataOe)
        else $error("write without data drive");
    a_read_float: assert property (@(posedge mclk) disable iff (!arst_n)
        (!chipSel_n && readNotWrite) |-> !dataOe)
        else $error("host drives bus during read");
    a_read_width: assert property (@(posedge mclk) disable iff (!arst_n)
        ($fell(chipSel_n) && readNotWrite) |-> !chipSel_n [*3])
        else $error("read select too short");
    a_chan_stable: assert property (@(posedge mclk) disable iff (!arst_n)
        !chipSel_n |=> $stable(channel_select) || chipSel_n)
        else $error("channel moved while selected");
    a_rst_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(devReset) |=> !devReset ##1 chipSel_n)
        else $error("reset pulse malformed");
    a_release_gap: assert property (@(posedge mclk) disable iff (!arst_n)
        ($rose(chipSel_n) && readNotWrite) |-> busy [*3])
        else $error("next access before bus release");
    a_one_word: assert property (@(posedge mclk) disable iff (!arst_n)
        (!chipSel_n && dataOe) |=> $stable(dataOut) || chipSel_n)
        else $error("write word changed in access");
    c_write: cover property (@(posedge mclk) $fell(chipSel_n) && !readNotWrite);
    c_read: cover property (@(posedge mclk) rdValid);
    c_load: cover property (@(posedge mclk) $rose(load_outputs_strobe));
    c_reset: cover property (@(posedge mclk) $rose(devReset));
endmodule : dac_host_ctrl

// ---- design/dac_host_pkg.sv ----
package dac_host_pkg;
    // ------------------------------------------------------------
    // clock and word
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int DATA_W        = 16;

    // ------------------------------------------------------------
    // pin timing in nanoseconds
    // ------------------------------------------------------------
    localparam int T_READ_CS_NS   = 150;  // select low for read
    localparam int T_RW_SETUP_NS  = 10;   // read line set before select
    localparam int T_HOLD_NS      = 10;   // lines held after select high
    localparam int T_BUS_REL_NS   = 100;  // bus released after select high
    localparam int T_WRITE_CS_NS  = 40;   // select low for write
    localparam int T_LOAD_HIGH_NS = 100;  // load strobe high
    localparam int T_LOAD_LOW_NS  = 100;  // load strobe low
    localparam int T_RST_HIGH_NS  = 10;   // reset high
    localparam int T_RST_LOW_NS   = 10;   // reset low

    // least times round up, never below one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    localparam int CNT_W         = 4;
    localparam int C_SETUP       = cyc_min(T_RW_SETUP_NS);
    localparam int C_READ        = cyc_min(T_READ_CS_NS);
    localparam int C_WRITE       = cyc_min(T_WRITE_CS_NS);
    localparam int C_HOLD        = cyc_min(T_HOLD_NS);
    localparam int C_RELEASE     = cyc_min(T_BUS_REL_NS);
    localparam int C_LOAD_HIGH   = cyc_min(T_LOAD_HIGH_NS);
    localparam int C_LOAD_LOW    = cyc_min(T_LOAD_LOW_NS);
    localparam int C_RST_HIGH    = cyc_min(T_RST_HIGH_NS);
    localparam int C_RST_LOW     = cyc_min(T_RST_LOW_NS);
    localparam int C_SYNC        = 2;  // sync stages on the returned bus

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_SETUP, ST_ACCESS, ST_HOLD, ST_RELEASE,
        ST_LOAD_HIGH, ST_LOAD_LOW, ST_RST_HIGH, ST_RST_LOW
    } seq_state_t;
endpackage : dac_host_pkg

// ---- sim/dac_dev_model.sv ----
`timescale 1ns/1ps
module dac_dev_model #(
    parameter logic [15:0] RST_CODE = 16'h8000  // variant reset code
) (
    input  wire logic        chipSel_n,
    input  wire logic        readNotWrite,
    input  wire logic        channel_select,
    input  wire logic        load_outputs_strobe,
    input  wire logic        devReset,
    input  wire logic [15:0] busWire,
    output logic      [15:0] devBus,
    output logic             devDrive,
    output logic      [15:0] outA,
    output logic      [15:0] outB
);
    logic [15:0] inA = 16'h0000;
    logic [15:0] inB = 16'h0000;
    logic [15:0] lastDrv = 16'h0000;
    // --------------------------------------------------------
    // edge triggered registers, only the readback drive follows a level
    // --------------------------------------------------------
    // reset edge sets all four registers
    always @(posedge devReset) begin
        inA = RST_CODE;
        inB = RST_CODE;
        outA = RST_CODE;
        outB = RST_CODE;
    end
    // write captured as select rises, outputs untouched
    always @(posedge chipSel_n) begin
        if (!readNotWrite && !channel_select) inA = busWire;
        if (!readNotWrite && channel_select) inB = busWire;
        if (readNotWrite) lastDrv = channel_select ? inB : inA;
    end
    // load edge copies both channels together, words unsigned
    always @(posedge load_outputs_strobe) begin
        if (chipSel_n) begin
            outA = inA;
            outB = inB;
        end
    end
    // readback drive, released bus shows inverse of last word
    assign devDrive = !chipSel_n && readNotWrite;
    assign devBus = devDrive ? (channel_select ? inB : inA) : ~lastDrv;
endmodule : dac_dev_model

// ---- sim/test_dual_dac_parallel_register_interface.sv ----
`timescale 1ns/1ps
module test_dual_dac_parallel_register_interface;
    import dac_host_pkg::*;
    typedef struct packed { logic ch; logic [15:0] d; } row_t;
    localparam logic [15:0] RST_CODE = 16'h8000;
    logic mclk = 1'b0, arst_n = 1'b0, wrReq = 1'b0, rdReq = 1'b0;
    logic loadReq = 1'b0, rstReq = 1'b0, chanSel = 1'b0;
    logic [15:0] wrData = 16'h0000;
    logic busy, rdValid, chipSel_n, readNotWrite, channel_select;
    logic load_outputs_strobe, devReset, dataOe, devDrive;
    logic [15:0] rdData, dataIn, dataOut, devBus, outA, outB;
    logic [15:0] expOut [2];
    int n_fail = 0, n_checks = 0;
    int nValid = 0, nReads = 0;
    row_t rows [4] = '{'{1'b0, 16'h0000}, '{1'b1, 16'hffff},
                       '{1'b0, 16'h8001}, '{1'b1, 16'h0001}};
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    assign dataIn = dataOe ? dataOut : devBus;
    dac_host_ctrl DUT (.mclk(mclk), .arst_n(arst_n), .wrReq(wrReq), .rdReq(rdReq),
        .loadReq(loadReq), .rstReq(rstReq), .chanSel(chanSel), .wrData(wrData),
        .busy(busy), .rdValid(rdValid), .rdData(rdData), .chipSel_n(chipSel_n),
        .readNotWrite(readNotWrite), .channel_select(channel_select),
        .load_outputs_strobe(load_outputs_strobe), .devReset(devReset),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
    dac_dev_model #(.RST_CODE(RST_CODE)) dev (.chipSel_n(chipSel_n),
        .readNotWrite(readNotWrite), .channel_select(channel_select),
        .load_outputs_strobe(load_outputs_strobe), .devReset(devReset),
        .busWire(dataIn), .devBus(devBus), .devDrive(devDrive),
        .outA(outA), .outB(outB));
    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic waitIdle;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (busy === 1'b0) break;
        end
        chk("busy", {15'h0, busy}, 16'h0000);
    endtask : waitIdle
    // kind: 0 reset, 1 load, 2 write, 3 read, 4 write and read together
    task automatic op(input int kind, input logic ch, input logic [15:0] d);
        @(posedge mclk);
        chanSel <= ch;
        wrData <= d;
        rstReq <= (kind == 0);
        loadReq <= (kind == 1);
        wrReq <= (kind == 2 || kind == 4);
        rdReq <= (kind == 3 || kind == 4);
        if (kind == 3) nReads++;
        @(posedge mclk);
        {rstReq, loadReq, wrReq, rdReq} <= 4'h0;
        waitIdle();
        if (kind >= 3) chk("rdValid", 16'(nValid), 16'(nReads));
    endtask : op
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // --------------------------------------------------------
    // bus ownership and load timing monitors
    // --------------------------------------------------------
    always @(posedge mclk) if (devDrive && dataOe) chk("busOwner", 16'h1, 16'h0);
    always @(posedge load_outputs_strobe) chk("csAtLoad", {15'h0, chipSel_n}, 16'h1);
    // one-cycle readback pulses counted
    always @(posedge mclk) if (rdValid === 1'b1) nValid++;
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        waitIdle();
        chk("outA", outA, RST_CODE);
        chk("outB", outB, RST_CODE);
        expOut = '{RST_CODE, RST_CODE};
        $display("test power-up reset done");
        for (int r = 0; r < 4; r++) begin
            op(2, rows[r].ch, rows[r].d);
            chk("outA", outA, expOut[0]);
            chk("outB", outB, expOut[1]);
            op(3, rows[r].ch, 16'h0000);
            chk("rdData", rdData, rows[r].d);
            op(1, 1'b0, 16'h0000);
            expOut[rows[r].ch] = rows[r].d;
            chk("outA", outA, expOut[0]);
            chk("outB", outB, expOut[1]);
        end
        $display("test table rows done");
        // back-to-back writes, then one load moves both
        op(2, 1'b0, 16'h1234);
        op(2, 1'b1, 16'h5678);
        op(1, 1'b0, 16'h0000);
        chk("outA", outA, 16'h1234);
        chk("outB", outB, 16'h5678);
        $display("test dual update done");
        // write and read asked together: write wins, no readback pulse
        op(4, 1'b1, 16'h2222);
        op(3, 1'b1, 16'h0000);
        chk("rdData", rdData, 16'h2222);
        $display("test request priority done");
        // second request while busy must be ignored
        @(posedge mclk);
        chanSel <= 1'b0;
        wrData <= 16'h0f0f;
        wrReq <= 1'b1;
        @(posedge mclk);
        wrData <= 16'hf0f0;
        @(posedge mclk);
        wrReq <= 1'b0;
        waitIdle();
        op(3, 1'b0, 16'h0000);
        chk("rdData", rdData, 16'h0f0f);
        repeat (20) @(posedge mclk);
        chk("outA", outA, 16'h1234);
        $display("test busy refusal done");
        // reset request mid-run sets all four registers to RST_CODE
        op(0, 1'b0, 16'h0000);
        chk("outA", outA, RST_CODE);
        chk("outB", outB, RST_CODE);
        op(3, 1'b1, 16'h0000);
        chk("rdData", rdData, RST_CODE);
        $display("test reset request done");
        // asynchronous reset mid-run, host pulses the device again
        op(2, 1'b0, 16'h4321);
        op(1, 1'b0, 16'h0000);
        chk("outA", outA, 16'h4321);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        waitIdle();
        chk("outA", outA, RST_CODE);
        chk("outB", outB, RST_CODE);
        $display("test async reset done");
        conclude();
    end
    // watchdog well beyond the expected run
    initial begin
        #(CLK_PERIOD_NS * 4000);
        n_fail++;
        conclude();
    end
endmodule : test_dual_dac_parallel_register_interface
